// >>> hdl/mpg_regs.vh
// Register indices, field masks and reset values of the port block
`ifndef MPG_REGS_VH
`define MPG_REGS_VH

// Register index; byte address is four times the index
`define MPG_IDX_PA_DATA   6'h00
`define MPG_IDX_PA_DIR    6'h01
`define MPG_IDX_PA_OPT    6'h02
`define MPG_IDX_PB_DATA   6'h03
`define MPG_IDX_PB_DIR    6'h04
`define MPG_IDX_PB_OPT    6'h05
`define MPG_IDX_PC_DATA   6'h06
`define MPG_IDX_PC_DIR    6'h07
`define MPG_IDX_PC_OPT    6'h08
`define MPG_IDX_PD_DATA   6'h09
`define MPG_IDX_PD_DIR    6'h0a
`define MPG_IDX_PD_OPT    6'h0b
`define MPG_IDX_PE_DATA   6'h0c
`define MPG_IDX_PE_DIR    6'h0d
`define MPG_IDX_PE_OPT    6'h0e
`define MPG_IDX_PF_DATA   6'h0f
`define MPG_IDX_PF_DIR    6'h10
`define MPG_IDX_PF_OPT    6'h11
`define MPG_IDX_PG_DATA   6'h12
`define MPG_IDX_PG_DIR    6'h13
`define MPG_IDX_PG_OPT    6'h14
`define MPG_IDX_PH_DATA   6'h15
`define MPG_IDX_PH_DIR    6'h16
`define MPG_IDX_PH_OPT    6'h17
`define MPG_IDX_IRQ_STAT  6'h18
`define MPG_IDX_IRQ_MASK  6'h19
`define MPG_IDX_LAST      6'h19

`define MPG_PORT_RESET    8'h00
`define MPG_STAT_RESET    4'h0

// Pin classes, bit 8*port+pin, port A in the low byte
`define MPG_INT_PU_PINS   64'h0000_0300_0000_7707
`define MPG_INT_FL_PINS   64'h0000_0400_0000_8808
`define MPG_TRUE_OD_PINS  64'h0000_0000_0000_00c0
`define MPG_PU_ONLY_PINS  64'h0000_0004_0000_0000

// Pins feeding each of the four external interrupt vectors
`define MPG_VEC0_PINS     64'h0000_0000_0000_000f
`define MPG_VEC1_PINS     64'h0000_0700_0000_0000
`define MPG_VEC2_PINS     64'h0000_0000_0000_0f00
`define MPG_VEC3_PINS     64'h0000_0000_0000_f000

// Sensitivity codes, two bits per vector
`define MPG_SENS_LOW      2'b00
`define MPG_SENS_RISE     2'b01
`define MPG_SENS_FALL     2'b10
`define MPG_SENS_BOTH     2'b11

`endif

// >>> hdl/mpg_top.v
// Eight byte-wide general purpose ports with AHB-Lite register access
//
// What this block does
// - Input pin with peripheral output enabled reads back the peripheral level.
// - Output pin feeds its data latch level to the peripheral input.
// - Pins unaffected by wait or halt; pin interrupts drive the wake output.
// - Pin event interrupts only if pin is interrupt input; ext_int_req also needs CPU unmasked, irq uses the mask register.
// - Pin interrupt enable comes only from direction and option bits.
// - Standard pins: 00 float, 01 pull-up, 10 open-drain, 11 push-pull.
// - Interrupt pull-up pins: direction 0, option 1 is pull-up interrupt.
// - Interrupt floating pins: direction 0, option 1 is floating interrupt.
// - Port A pins 7:6 are true open-drain; option bit ignored.
// - Port E pin 2 is pull-up input only, push-pull when CAN transmits.
// - Three registers per port, A to H in order, all reset to zero.
// - Input pin: data read gives live pin, write only updates latch.
// - Output pin: latch drives pin, data read gives the latch.
// - Enabled peripheral overrides the port's drive setup; its output forces output mode.
// - Vector events qualified by sensitivity, ORed, latch cleared on fetch.
`timescale 1ns/1ns
`include "mpg_regs.vh"

module mpg_top #(
    parameter [63:0] IMPL_MASK = 64'hffff_ffff_ffff_ffff
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [63:0] pin_in,
    output reg  [63:0] pin_out,
    output reg  [63:0] pin_oe_n,
    output reg  [63:0] pin_pullup_en,
    input  wire [63:0] alt_out_en,
    input  wire [63:0] alt_out,
    input  wire [63:0] alt_open_drain,
    output reg  [63:0] alt_in,
    input  wire [7:0]  ext_int_sensitivity,
    input  wire        cond_code_int_mask,
    input  wire [3:0]  vector_fetch,
    output reg  [3:0]  ext_int_req,
    output reg         wake,
    output reg         irq
);

    // Register state
    reg  [63:0] data_latch_q;
    reg  [63:0] dir_q;
    reg  [63:0] opt_q;
    reg  [3:0]  stat_q;
    reg  [3:0]  mask_q;
    reg  [3:0]  pend_q;
    reg  [7:0]  sens_q;

    // Pin synchroniser and filtered level
    reg  [63:0] sync1_q;
    reg  [63:0] sync2_q;
    reg  [63:0] sync3_q;
    reg  [63:0] lvl_q;
    reg  [63:0] lvl_prev_q;
    wire [63:0] lvl_d;

    // Bus pipeline
    reg         wr_pend_q;
    reg         rd_pend_q;
    reg  [5:0]  idx_q;
    wire        addr_ok;

    // Per-pin decoded configuration
    wire [63:0] drive_en;
    wire [63:0] drive_val;
    wire [63:0] pull_en;
    wire [63:0] int_en;
    wire [63:0] rd_val;
    wire [63:0] alt_in_d;

    reg  [3:0]  pend_set;
    reg  [3:0]  pend_d;
    reg  [3:0]  stat_d;
    reg  [31:0] rd_word;
    integer     p;

    // Qualify each pin against one sensitivity code
    function [63:0] sens_hit;
        input [1:0]  sens;
        input [63:0] now;
        input [63:0] prev;
        begin
            case (sens)
                `MPG_SENS_LOW:  sens_hit = ~now;
                `MPG_SENS_RISE: sens_hit = now & ~prev;
                `MPG_SENS_FALL: sens_hit = ~now & prev;
                `MPG_SENS_BOTH: sens_hit = now ^ prev;
                default:        sens_hit = 64'h0000_0000_0000_0000;
            endcase
        end
    endfunction

    // Per-pin mode decode
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1) begin : g_pin
            localparam TOD   = `MPG_TRUE_OD_PINS >> g & 64'h1;
            localparam PUO   = `MPG_PU_ONLY_PINS >> g & 64'h1;
            localparam INTPU = `MPG_INT_PU_PINS >> g & 64'h1;
            localparam INTFL = `MPG_INT_FL_PINS >> g & 64'h1;
            wire dir = dir_q[g] & (PUO == 64'h0);
            wire opt = opt_q[g];
            wire lat = data_latch_q[g];
            wire alt = alt_out_en[g];
            // Peripheral drive wins; true open-drain stays open-drain
            wire alt_od = alt_open_drain[g] | (TOD != 64'h0);
            wire pp = opt & (TOD == 64'h0);

            assign drive_en[g]  = alt ? (alt_od ? ~alt_out[g] : 1'b1) :
                                  dir ? (pp ? 1'b1 : ~lat) : 1'b0;
            assign drive_val[g] = alt ? (alt_od ? 1'b0 : alt_out[g]) :
                                  (pp ? lat : 1'b0);
            // Pull-up off for floating interrupt and true open-drain pins
            assign pull_en[g]   = (PUO != 64'h0) ? ~alt :
                                  ~dir & opt & (TOD == 64'h0) &
                                  (INTFL == 64'h0);
            assign int_en[g]    = ~dir & opt &
                                  ((INTPU | INTFL) != 64'h0);
            assign rd_val[g]    = IMPL_MASK[g] &
                                  (dir ? lat :
                                   alt ? alt_out[g] : lvl_q[g]);
            assign alt_in_d[g]  = dir ? lat : lvl_q[g];
        end
    endgenerate

    // Level counts once the second and third stages agree
    assign lvl_d = (~(sync2_q ^ sync3_q) & sync3_q) |
                   ((sync2_q ^ sync3_q) & lvl_q);

    assign addr_ok = hsel & htrans[1] & hready;

    // Event qualification and request latch, set wins over clear
    always @* begin
        pend_set[0] = |(`MPG_VEC0_PINS & int_en &
                        sens_hit(sens_q[1:0], lvl_q, lvl_prev_q));
        pend_set[1] = |(`MPG_VEC1_PINS & int_en &
                        sens_hit(sens_q[3:2], lvl_q, lvl_prev_q));
        pend_set[2] = |(`MPG_VEC2_PINS & int_en &
                        sens_hit(sens_q[5:4], lvl_q, lvl_prev_q));
        pend_set[3] = |(`MPG_VEC3_PINS & int_en &
                        sens_hit(sens_q[7:6], lvl_q, lvl_prev_q));
        // Changing the sensitivity drops a stale request
        pend_d = pend_q & ~vector_fetch;
        if (sens_q != ext_int_sensitivity) begin
            pend_d = 4'h0;
        end
        pend_d = pend_d | pend_set;
        stat_d = stat_q;
        if (wr_pend_q && idx_q == `MPG_IDX_IRQ_STAT) begin
            stat_d = stat_q & ~hwdata[3:0];
        end
        stat_d = stat_d | pend_set;
    end

    // Read mux
    always @* begin
        rd_word = 32'h0000_0000;
        for (p = 0; p < 8; p = p + 1) begin
            if (idx_q == 3 * p) begin
                rd_word[7:0] = rd_val[8*p +: 8];
            end
            if (idx_q == 3 * p + 1) begin
                rd_word[7:0] = dir_q[8*p +: 8] & IMPL_MASK[8*p +: 8];
            end
            if (idx_q == 3 * p + 2) begin
                rd_word[7:0] = opt_q[8*p +: 8] & IMPL_MASK[8*p +: 8];
            end
        end
        if (idx_q == `MPG_IDX_IRQ_STAT) begin
            rd_word[3:0] = stat_q;
        end
        if (idx_q == `MPG_IDX_IRQ_MASK) begin
            rd_word[3:0] = mask_q;
        end
    end

    // Bus slave: writes zero wait, reads one wait state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q     <= 6'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            hresp     <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            rd_pend_q <= addr_ok & ~hwrite;
            if (addr_ok) begin
                // Index beyond the map decodes to nothing
                idx_q <= haddr[7:2];
            end
            if (addr_ok && !hwrite) begin
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (rd_pend_q) begin
                hrdata <= rd_word;
            end
        end
    end

    // Port registers, all clear to floating input except the pull-up-only Port E pin 2
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_latch_q <= {8{`MPG_PORT_RESET}};
            dir_q        <= {8{`MPG_PORT_RESET}};
            opt_q        <= {8{`MPG_PORT_RESET}};
            mask_q       <= `MPG_STAT_RESET;
        end else if (wr_pend_q) begin
            for (p = 0; p < 8; p = p + 1) begin
                if (idx_q == 3 * p) begin
                    data_latch_q[8*p +: 8] <= hwdata[7:0];
                end
                if (idx_q == 3 * p + 1) begin
                    dir_q[8*p +: 8] <= hwdata[7:0];
                end
                if (idx_q == 3 * p + 2) begin
                    opt_q[8*p +: 8] <= hwdata[7:0];
                end
            end
            if (idx_q == `MPG_IDX_IRQ_MASK) begin
                mask_q <= hwdata[3:0];
            end
        end
    end

    // Pin sampling and interrupt state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q     <= 64'h0000_0000_0000_0000;
            sync2_q     <= 64'h0000_0000_0000_0000;
            sync3_q     <= 64'h0000_0000_0000_0000;
            lvl_q       <= 64'h0000_0000_0000_0000;
            lvl_prev_q  <= 64'h0000_0000_0000_0000;
            pend_q      <= 4'h0;
            sens_q      <= 8'h00;
            stat_q      <= `MPG_STAT_RESET;
            ext_int_req <= 4'h0;
            wake        <= 1'b0;
            irq         <= 1'b0;
        end else begin
            sync1_q     <= pin_in;
            sync2_q     <= sync1_q;
            sync3_q     <= sync2_q;
            lvl_q       <= lvl_d;
            lvl_prev_q  <= lvl_q;
            sens_q      <= ext_int_sensitivity;
            pend_q      <= pend_d;
            stat_q      <= stat_d;
            ext_int_req <= pend_d & {4{~cond_code_int_mask}};
            // Wake ignores the CPU mask so halt can always be left
            wake        <= |pend_d;
            irq         <= |(stat_d & mask_q);
        end
    end

    // Registered pad controls
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out       <= 64'h0000_0000_0000_0000;
            pin_oe_n      <= 64'hffff_ffff_ffff_ffff;
            pin_pullup_en <= 64'h0000_0000_0000_0000;
            alt_in        <= 64'h0000_0000_0000_0000;
        end else begin
            pin_out       <= drive_val;
            pin_oe_n      <= ~drive_en;
            pin_pullup_en <= pull_en;
            alt_in        <= alt_in_d;
        end
    end

endmodule // mpg_top

// >>> dv/mpg_pin_model.sv
// Board side of the pads: external drivers and pull resolution
`timescale 1ns/1ns
module mpg_pin_model (
    input  wire [63:0] pin_out,
    input  wire [63:0] pin_oe_n,
    input  wire [63:0] pin_pullup_en,
    input  wire [63:0] ext_en,
    input  wire [63:0] ext_val,
    output wire [63:0] pin_level
);
    // Chip drive wins; a floating pad shows the inverse so x never hides
    assign pin_level = (~pin_oe_n & pin_out)
        | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & (pin_pullup_en | ~pin_out));
endmodule // mpg_pin_model

// >>> dv/mpg_chk.sv
// Concurrent checks on the port block top-level pins
`timescale 1ns/1ns
module mpg_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire [63:0] pin_out,
    input wire [63:0] pin_oe_n,
    input wire [63:0] pin_pullup_en,
    input wire [63:0] alt_out_en,
    input wire [63:0] alt_out,
    input wire [63:0] alt_open_drain,
    input wire        cond_code_int_mask,
    input wire [3:0]  ext_int_req,
    input wire        wake
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && htrans[1] && hready;
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait");
    property p_rst_pins; $rose(hresetn) |-> &pin_oe_n && ext_int_req == 4'h0;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("reset pins");
    property p_od_low; (pin_out[7:6] & ~pin_oe_n[7:6]) == 2'b00;
    endproperty
    a_od_low: assert property (p_od_low) else $error("od high");
    property p_e2_pull; $past(hresetn) && !$past(alt_out_en[34])
        |-> pin_oe_n[34] && pin_pullup_en[34]; endproperty
    a_e2_pull: assert property (p_e2_pull) else $error("e2 pull");
    property p_e2_can; $past(hresetn) && $past(alt_out_en[34])
        |-> !pin_oe_n[34] && pin_out[34] == $past(alt_out[34]); endproperty
    a_e2_can: assert property (p_e2_can) else $error("e2 can");
    property p_alt_drv; $past(alt_out_en[16]) && !$past(alt_open_drain[16])
        |-> !pin_oe_n[16] && pin_out[16] == $past(alt_out[16]); endproperty
    a_alt_drv: assert property (p_alt_drv) else $error("alt drive");
    property p_req_mask; cond_code_int_mask |=> ext_int_req == 4'h0;
    endproperty
    a_req_mask: assert property (p_req_mask) else $error("req mask");
    property p_req_wake; ext_int_req != 4'h0 |-> wake; endproperty
    a_req_wake: assert property (p_req_wake) else $error("wake");
endmodule // mpg_chk
bind mpg_top mpg_chk u_chk (.*);

// >>> dv/mpg_tb_top.sv
// Self-checking bench for the port block
`timescale 1ns/1ns
`include "mpg_regs.vh"
module mpg_tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hready, hreadyout, hresp, wake, irq;
    logic        cond_code_int_mask = 1'b0;
    logic [63:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, alt_in;
    logic [63:0] alt_out_en = 64'h0, alt_out = 64'h0;
    logic [63:0] alt_open_drain = 64'h0, ext_val = 64'h0;
    logic [63:0] ext_en = {64{1'b1}};
    logic [7:0]  ext_int_sensitivity = 8'h55;
    logic [3:0]  vector_fetch = 4'h0, ext_int_req;
    int          n_fail = 0, checks = 0, cyc = 0;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    mpg_top u_dut (.*);
    mpg_pin_model u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_level(pin_in));
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // Master waits on hready only; no latency is assumed
    task automatic bus(input logic w, input logic [5:0] i,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, i, 2'b00};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, i, {24'h0, d});
    endtask
    task automatic rc(input string n, input logic [5:0] i,
                      input logic [7:0] e);
        bus(1'b0, i, 32'h0);
        chk(n, {56'h0, e}, {32'h0, rd});
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        chk("oe_n", {64{1'b1}}, pin_oe_n);
        @(posedge hclk);
        for (int i = 0; i < 24; i++) rc("reset", 6'(i), 8'h00);
        chk("e2 pull", 1'b1, pin_pullup_en[34]);
        for (int p = 0; p < 8; p++) begin
            wr(6'(3*p+1), 8'ha0 + 8'(p));
            wr(6'(3*p+2), 8'h50 + 8'(p));
        end
        for (int p = 0; p < 8; p++) begin
            rc("dir", 6'(3*p+1), 8'ha0 + 8'(p));
            rc("opt", 6'(3*p+2), 8'h50 + 8'(p));
            wr(6'(3*p+1), 8'h00);
            wr(6'(3*p+2), 8'h00);
        end
        wr(6'h1a, 8'hff);
        rc("unmapped", 6'h1a, 8'h00);
        ext_val <= 64'h0123_4567_89ab_cdef;
        wr(`MPG_IDX_PC_DATA, 8'hff);
        repeat (6) @(posedge hclk);
        chk("in oe_n", {64{1'b1}}, pin_oe_n);
        chk("no int", 5'h00, {wake, ext_int_req});
        for (int p = 0; p < 8; p++)
            rc("pin", 6'(3*p), ext_val[8*p+:8]);
        wr(`MPG_IDX_PC_DATA, 8'h5a);
        wr(`MPG_IDX_PC_OPT, 8'hf0);
        wr(`MPG_IDX_PC_DIR, 8'hff);
        wr(`MPG_IDX_PD_OPT, 8'hff);
        repeat (2) @(posedge hclk);
        chk("c oe_n", 8'h0a, pin_oe_n[23:16]);
        chk("c out", 8'h50, pin_out[23:16] & ~pin_oe_n[23:16]);
        chk("d pull", 8'hff, pin_pullup_en[31:24]);
        rc("c latch", `MPG_IDX_PC_DATA, 8'h5a);
        wr(`MPG_IDX_PD_DATA, 8'h96);
        wr(`MPG_IDX_PD_DIR, 8'hff);
        repeat (2) @(posedge hclk);
        chk("alt in", 8'h96, alt_in[31:24]);
        wr(`MPG_IDX_PA_DATA, 8'h40);
        wr(`MPG_IDX_PA_OPT, 8'hc0);
        wr(`MPG_IDX_PA_DIR, 8'hc0);
        repeat (2) @(posedge hclk);
        chk("od oe_n", 2'b01, pin_oe_n[7:6]);
        wr(`MPG_IDX_PC_DIR, 8'h00);
        alt_out_en <= 64'h4_0001_0000; // No interrupt pin here
        alt_out <= 64'h4_0000_0000;
        repeat (2) @(posedge hclk);
        chk("can oe_n", 1'b0, pin_oe_n[34]);
        chk("can out", 1'b1, pin_out[34]);
        chk("alt oe_n", 1'b0, pin_oe_n[16]);
        alt_open_drain <= 64'h1_0000;
        alt_out[16] <= 1'b1;
        ext_val[16] <= 1'b0;
        repeat (6) @(posedge hclk);
        rc("alt read", `MPG_IDX_PC_DATA, 8'hab);
        chk("hresp", 1'b0, hresp);
        alt_out_en <= 64'h0;
        ext_int_sensitivity <= 8'h56;
        wr(`MPG_IDX_PA_OPT, 8'hc9);
        wr(`MPG_IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        chk("a pull", 4'h1, pin_pullup_en[3:0]);
        ext_val[0] <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("req", 4'h1, ext_int_req);
        chk("irq on", 1'b1, irq);
        rc("stat", `MPG_IDX_IRQ_STAT, 8'h01);
        wr(`MPG_IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge hclk);
        chk("irq off", 1'b0, irq);
        wr(`MPG_IDX_IRQ_STAT, 8'h01);
        rc("stat clr", `MPG_IDX_IRQ_STAT, 8'h00);
        cond_code_int_mask <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("cpu mask", 5'h10, {wake, ext_int_req});
        vector_fetch <= 4'h1;
        @(posedge hclk);
        vector_fetch <= 4'h0;
        cond_code_int_mask <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("fetch", 1'b0, wake);
        ext_val[3] <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("or req", 4'h1, ext_int_req);
        finish_test();
    end
endmodule // mpg_tb_top
